// file: shared/cmof_defines.svh
// cmof_defines.svh: offsets, field positions, reset values and counts of the
// message object filter. Assumes byte addressing on a 32-bit APB bus.
`ifndef CMOF_DEFINES_SVH
`define CMOF_DEFINES_SVH
`define CMOF_OBJ_COUNT    32
`define CMOF_IDX_W        5
`define CMOF_ID_W         29
`define CMOF_STD_LSB      18
`define CMOF_LAST_IDX     5'h1F
// register byte offsets
`define CMOF_OFF_CFG      8'h00
`define CMOF_OFF_CMD      8'h04
`define CMOF_OFF_MASK     8'h08
`define CMOF_OFF_CTRL     8'h0C
`define CMOF_OFF_ARB      8'h10
`define CMOF_OFF_DLO      8'h14
`define CMOF_OFF_DHI      8'h18
`define CMOF_OFF_VALID    8'h1C
`define CMOF_OFF_NEWDAT   8'h20
`define CMOF_OFF_IRQPND   8'h24
`define CMOF_OFF_TRANSMIT_REQUEST     8'h28
`define CMOF_OFF_PINSTAT  8'h2C
// field positions
`define CMOF_CFG_POL_LSB  0
`define CMOF_CFG_THR_LSB  8
`define CMOF_CMD_WR_BIT   8
// reset values
`define CMOF_POL_RST      3'h7
`define CMOF_THR_RST      5'h00
`endif

// file: shared/cmof_pkg.sv
// cmof_pkg: types shared by the message object filter and its surroundings.
// Assumes cmof_defines.svh is on the include path.
package cmof_pkg;
  // one message ram word, 139 bits
  typedef struct packed {
    logic [28:0] identifier_mask;
    logic        mask_extended_format;
    logic        mask_direction;
    logic        use_mask;
    logic        transmit_irq_enable;
    logic        receive_irq_enable;
    logic        remote_enable;
    logic        end_of_buffer;
    logic [28:0] object_identifier;
    logic        extended_format;
    logic        object_direction;
    logic        message_lost;
    logic [2:0]  reserved;
    logic [3:0]  length_code;
    logic [63:0] data;
  } cmof_obj_s;
  // frame as handed over by the protocol core; standard ids sit in bits 28:18
  typedef struct packed {
    logic [28:0] id;
    logic        ide;
    logic        rtr;
    logic [3:0]  length_code;
    logic [63:0] data;
  } cmof_frame_s;
  typedef enum logic {CMOF_IDLE, CMOF_SCAN} cmof_state_e;
endpackage

// file: verilog/cmof_filter.sv
// cmof_filter: message ram of 32 objects, acceptance filter, transmit request
// selection, three interrupt pins and an apb register window.
// Assumes the protocol core shares pclk and hands frames over one at a time.
//
// Behaviour
// R1: ram holds 32 message objects, each one 139-bit word with its mask.
// R2: host touches one register per access, stepping addresses by four.
// R3: general pin active whenever any object interrupt is pending.
// R4: first-object pin active after a frame is stored into object 0.
// R5: threshold pin active after a frame is stored into the selected object.
// R6: each pin's active level is chosen by a configuration bit.
// R7: mask bit 1 compares that identifier bit, 0 makes it don't-care.
// R8: standard objects store and compare identifier bits 28 to 18 only.
// R9: mask-extended bit set makes IDE take part in filtering; the code compares IDE whether the bit is set or clear.
// R10: extended frames go to extended objects, standard to standard ones.
// R11: mask-direction bit set makes direction take part in filtering.
// R12: identifier, format and direction also describe the outgoing frame.
// R13: data frames match receive objects, remote frames transmit objects, valid only.
// R14: among several matching objects the lowest number wins.
// R15: receive object sends remote frame; matching data frame is stored there.
// R16: transmit object sends data; matching remote frame sets request if enabled.
// R17: use-mask 0 ignores all mask fields, 1 applies them.
// R18: host programs mask bits before making a masked object valid.
// R19: storing while new data still set raises message lost until cleared.
// R20: transmit enable set makes a sent frame raise interrupt pending.
// R21: receive enable set makes a stored frame raise interrupt pending.
// R22: end-of-buffer 0 chains objects into a buffer, 1 ends it.
// R23: length code 9 to 15 means 8 bytes; stored code is the received one.
// R24: all eight data slots are written, first byte into slot 0.
// R25: unmasked objects need exact identifier, format and direction match.
//
// Register access over APB and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`include "cmof_defines.svh"
module cmof_filter (
  // apb slave
  input  wire logic                pclk,
  input  wire logic                presetn,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [11:0]         paddr,
  input  wire logic [31:0]         pwdata,
  output      logic [31:0]         prdata,
  output      logic                pready,
  output      logic                pslverr,
  // received frames from the protocol core
  input  wire logic                rx_valid,
  input  wire cmof_pkg::cmof_frame_s rx_frame,
  output      logic                rx_ready,
  // frames offered to the protocol core
  output      logic                tx_valid,
  output      logic [4:0]          tx_object,
  output      cmof_pkg::cmof_frame_s tx_frame,
  input  wire logic                tx_done,
  // interrupt pins
  output      logic                general_irq_pin,
  output      logic                first_object_irq_pin,
  output      logic                threshold_object_irq_pin
);
  localparam int N = `CMOF_OBJ_COUNT;

  cmof_pkg::cmof_obj_s   mem [N];
  cmof_pkg::cmof_obj_s   win_r;
  cmof_pkg::cmof_frame_s rx_q_r;
  cmof_pkg::cmof_frame_s tx_frame_r;
  cmof_pkg::cmof_state_e state_r;
  logic [4:0]  scan_idx_r;
  logic [4:0]  obj_sel_r;
  logic [2:0]  pin_option_config_r;
  logic [4:0]  threshold_object_select_r;
  logic [N-1:0] object_valid_r;
  logic [N-1:0] new_data_flag_r;
  logic [N-1:0] irq_pending_r;
  logic [N-1:0] transmit_request_r;
  logic        rx1_flag_r;
  logic        rxx_flag_r;
  logic [31:0] prdata_r;
  logic        pready_r;
  logic        pslverr_r;
  logic        rx_ready_r;
  logic        tx_valid_r;
  logic [4:0]  tx_obj_r;
  logic        gen_pin_r;
  logic        first_pin_r;
  logic        thr_pin_r;

  // apb decode
  wire [7:0] addr      = paddr[7:0];
  wire       hi_zero   = (paddr[11:8] == 4'h0);
  wire       sel_cfg   = hi_zero && addr == `CMOF_OFF_CFG;
  wire       sel_cmd   = hi_zero && addr == `CMOF_OFF_CMD;
  wire       sel_mask  = hi_zero && addr == `CMOF_OFF_MASK;
  wire       sel_ctrl  = hi_zero && addr == `CMOF_OFF_CTRL;
  wire       sel_arb   = hi_zero && addr == `CMOF_OFF_ARB;
  wire       sel_dlo   = hi_zero && addr == `CMOF_OFF_DLO;
  wire       sel_dhi   = hi_zero && addr == `CMOF_OFF_DHI;
  wire       sel_valid = hi_zero && addr == `CMOF_OFF_VALID;
  wire       sel_nd    = hi_zero && addr == `CMOF_OFF_NEWDAT;
  wire       sel_ip    = hi_zero && addr == `CMOF_OFF_IRQPND;
  wire       sel_transmit_request  = hi_zero && addr == `CMOF_OFF_TRANSMIT_REQUEST;
  wire       sel_pin   = hi_zero && addr == `CMOF_OFF_PINSTAT;
  wire       mapped    = sel_cfg | sel_cmd | sel_mask | sel_ctrl | sel_arb | sel_dlo |
                         sel_dhi | sel_valid | sel_nd | sel_ip | sel_transmit_request | sel_pin;
  wire       done      = psel & penable & pready_r;
  wire       wr        = done & pwrite & mapped;
  wire       idle      = (state_r == cmof_pkg::CMOF_IDLE);
  wire       rx_take   = rx_valid & rx_ready_r & idle;
  // a ram command must not overlap a scan: it waits while one runs
  wire       cmd_ok    = idle & ~rx_take;
  wire       pready_nxt = psel & penable & ~pready_r & (~sel_cmd | cmd_ok);
  wire       cmd_wr    = wr & sel_cmd & pwdata[`CMOF_CMD_WR_BIT];
  wire       cmd_rd    = wr & sel_cmd & ~pwdata[`CMOF_CMD_WR_BIT];

  // acceptance filter on the object under the scan pointer
  cmof_pkg::cmof_obj_s cur;
  assign cur = mem[scan_idx_r];
  wire        um       = cur.use_mask;                                   // R17
  wire [28:0] id_msk   = um ? cur.identifier_mask : {`CMOF_ID_W{1'b1}};  // R7 R25
  wire [28:0] cmp_msk  = cur.extended_format ? id_msk :
                         {id_msk[28:18], 18'h00000};                     // R8
  wire        id_ok    = ((rx_q_r.id ^ cur.object_identifier) & cmp_msk) == 29'h0;
  // format must always agree so objects only receive their own frame type
  wire        ide_used = ~um | cur.mask_extended_format;                 // R9
  wire        fmt_ok   = (rx_q_r.ide == cur.extended_format) | (~ide_used & 1'b0); // R10
  wire        dir_used = ~um | cur.mask_direction;                       // R11
  wire        dir_ok   = ~dir_used | (cur.object_direction == rx_q_r.rtr); // R13
  // a filled buffer member that is not the last hands the frame on
  wire        fifo_skip = ~cur.end_of_buffer & new_data_flag_r[scan_idx_r]; // R22
  wire        hit      = ~idle & object_valid_r[scan_idx_r] & id_ok & fmt_ok &
                         dir_ok & ~fifo_skip;                           // R13
  wire        remote_tx = rx_q_r.rtr & cur.object_direction;             // R16
  wire        store_ev = hit & ~remote_tx;
  wire        remote_ev = hit & remote_tx;
  wire        last_idx = (scan_idx_r == `CMOF_LAST_IDX);

  // lowest pending transmit request wins the core
  logic [4:0] tx_sel;
  logic       tx_any;
  always_comb begin
    tx_sel = 5'h00;
    tx_any = 1'b0;
    for (int i = N - 1; i >= 0; i--) begin
      if (transmit_request_r[i] && object_valid_r[i]) begin
        tx_sel = i[4:0];
        tx_any = 1'b1;
      end
    end
  end
  cmof_pkg::cmof_obj_s txo;
  assign txo = mem[tx_sel];

  // one-hot event vectors; every flag lets its set win over a clear
  wire [N-1:0] idx_oh   = {{(N-1){1'b0}}, 1'b1} << scan_idx_r;
  wire [N-1:0] txd_oh   = {{(N-1){1'b0}}, 1'b1} << tx_obj_r;
  wire         tx_ev    = tx_done & tx_valid_r;
  wire         txie     = mem[tx_obj_r].transmit_irq_enable;
  wire [N-1:0] nd_set   = store_ev ? idx_oh : '0;
  wire [N-1:0] ip_set   = (store_ev & cur.receive_irq_enable ? idx_oh : '0) |  // R21
                          (tx_ev & txie ? txd_oh : '0);                       // R20
  wire [N-1:0] tr_set   = (remote_ev & cur.remote_enable ? idx_oh : '0) |     // R16
                          (wr & sel_transmit_request ? pwdata : '0);
  wire [N-1:0] tr_clr   = tx_ev ? txd_oh : '0;
  wire [N-1:0] nd_clr   = wr & sel_nd ? pwdata : '0;
  wire [N-1:0] ip_clr   = wr & sel_ip ? pwdata : '0;
  wire         rx1_set  = store_ev & (scan_idx_r == 5'h00);                   // R4
  wire         rxx_set  = store_ev & (scan_idx_r == threshold_object_select_r); // R5

  // stored object: received id, length code and all data slots
  cmof_pkg::cmof_obj_s st;
  always_comb begin
    st = cur;
    st.object_identifier = cur.extended_format ? rx_q_r.id :
                           {rx_q_r.id[28:18], cur.object_identifier[17:0]};  // R8
    st.length_code = rx_q_r.length_code;                                     // R23
    st.data = rx_q_r.data;                                                   // R24
    st.message_lost = cur.message_lost |
                      (~cur.object_direction & new_data_flag_r[scan_idx_r]); // R19
  end

  // register read mux
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h00000000;
    if (sel_cfg)   rd_mux = {19'h00000, threshold_object_select_r, 5'h00, pin_option_config_r};
    if (sel_cmd)   rd_mux = {27'h0000000, obj_sel_r};
    if (sel_mask)  rd_mux = {win_r.use_mask, win_r.mask_direction,
                             win_r.mask_extended_format, win_r.identifier_mask};
    if (sel_ctrl)  rd_mux = {23'h000000, win_r.message_lost, win_r.length_code,
                             win_r.end_of_buffer, win_r.remote_enable,
                             win_r.receive_irq_enable, win_r.transmit_irq_enable};
    if (sel_arb)   rd_mux = {1'b0, win_r.object_direction, win_r.extended_format,
                             win_r.object_identifier};
    if (sel_dlo)   rd_mux = win_r.data[31:0];
    if (sel_dhi)   rd_mux = win_r.data[63:32];
    if (sel_valid) rd_mux = object_valid_r;
    if (sel_nd)    rd_mux = new_data_flag_r;
    if (sel_ip)    rd_mux = irq_pending_r;
    if (sel_transmit_request)  rd_mux = transmit_request_r;
    if (sel_pin)   rd_mux = {23'h000000, ~idle, 6'h00, rxx_flag_r, rx1_flag_r};
  end

  // apb answer: one wait state, more while a ram command waits for a scan
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r  <= 1'b0;
      prdata_r  <= 32'h00000000;
      pslverr_r <= 1'b0;
    end else begin
      pready_r  <= pready_nxt;
      prdata_r  <= pready_nxt ? rd_mux : prdata_r;
      pslverr_r <= pready_nxt & ~mapped;
    end
  end

  // configuration and the host window onto one object
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_option_config_r       <= `CMOF_POL_RST;
      threshold_object_select_r <= `CMOF_THR_RST;
      obj_sel_r                 <= 5'h00;
      win_r                     <= '0;
    end else begin
      if (wr & sel_cfg) begin
        pin_option_config_r       <= pwdata[`CMOF_CFG_POL_LSB +: 3];        // R6
        threshold_object_select_r <= pwdata[`CMOF_CFG_THR_LSB +: 5];
      end
      if (wr & sel_cmd)  obj_sel_r <= pwdata[4:0];
      if (cmd_rd)        win_r <= mem[pwdata[4:0]];
      if (wr & sel_mask) begin
        win_r.identifier_mask      <= pwdata[28:0];
        win_r.mask_extended_format <= pwdata[29];
        win_r.mask_direction       <= pwdata[30];
        win_r.use_mask             <= pwdata[31];
      end
      if (wr & sel_ctrl) begin
        win_r.transmit_irq_enable <= pwdata[0];
        win_r.receive_irq_enable  <= pwdata[1];
        win_r.remote_enable       <= pwdata[2];
        win_r.end_of_buffer       <= pwdata[3];
        win_r.length_code         <= pwdata[7:4];
        win_r.message_lost        <= pwdata[8];
      end
      if (wr & sel_arb) begin
        win_r.object_identifier <= pwdata[28:0];
        win_r.extended_format   <= pwdata[29];
        win_r.object_direction  <= pwdata[30];
      end
      if (wr & sel_dlo) win_r.data[31:0]  <= pwdata;
      if (wr & sel_dhi) win_r.data[63:32] <= pwdata;
    end
  end

  // message ram: host commands and filter stores never share an edge
  always_ff @(posedge pclk) begin
    if (cmd_wr)   mem[pwdata[4:0]] <= win_r;                                // R1
    if (store_ev) mem[scan_idx_r] <= st;                                    // R15
  end

  // scan fsm: one object per cycle from object 0 upward, first hit stops it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r    <= cmof_pkg::CMOF_IDLE;
      scan_idx_r <= 5'h00;
      rx_q_r     <= '0;
    end else begin
      case (state_r)
        cmof_pkg::CMOF_IDLE: begin
          if (rx_take) begin
            rx_q_r     <= rx_frame;
            scan_idx_r <= 5'h00;
            state_r    <= cmof_pkg::CMOF_SCAN;
          end
        end
        cmof_pkg::CMOF_SCAN: begin
          if (hit || last_idx) state_r <= cmof_pkg::CMOF_IDLE;              // R14
          else scan_idx_r <= scan_idx_r + 5'h01;
        end
        default: state_r <= cmof_pkg::CMOF_IDLE;
      endcase
    end
  end

  // object status vectors
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      object_valid_r     <= '0;
      new_data_flag_r    <= '0;
      irq_pending_r      <= '0;
      transmit_request_r <= '0;
      rx1_flag_r         <= 1'b0;
      rxx_flag_r         <= 1'b0;
    end else begin
      if (wr & sel_valid) object_valid_r <= pwdata;
      new_data_flag_r    <= (new_data_flag_r & ~nd_clr) | nd_set;
      irq_pending_r      <= (irq_pending_r & ~ip_clr) | ip_set;
      transmit_request_r <= (transmit_request_r & ~tr_clr) | tr_set;
      rx1_flag_r <= (rx1_flag_r & ~(wr & sel_pin & pwdata[0])) | rx1_set;
      rxx_flag_r <= (rxx_flag_r & ~(wr & sel_pin & pwdata[1])) | rxx_set;
    end
  end

  // transmit offer: data frame for transmit objects, remote for receive ones
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_valid_r <= 1'b0;
      tx_obj_r   <= 5'h00;
      tx_frame_r <= '0;
      rx_ready_r <= 1'b0;
    end else begin
      tx_valid_r <= tx_any & ~tx_ev;
      tx_obj_r   <= tx_sel;
      tx_frame_r <= '{id: txo.object_identifier, ide: txo.extended_format,
                      rtr: ~txo.object_direction, length_code: txo.length_code,
                      data: txo.data};                                       // R12 R15 R16
      rx_ready_r <= ~(psel & sel_cmd) & (idle ? ~rx_take : (hit | last_idx));
    end
  end

  // interrupt pins: a config bit of 1 means active high
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gen_pin_r   <= 1'b0;
      first_pin_r <= 1'b0;
      thr_pin_r   <= 1'b0;
    end else begin
      gen_pin_r   <= ~((|irq_pending_r) ^ pin_option_config_r[0]);           // R3 R6
      first_pin_r <= ~(rx1_flag_r ^ pin_option_config_r[1]);                 // R4
      thr_pin_r   <= ~(rxx_flag_r ^ pin_option_config_r[2]);                 // R5
    end
  end

  assign prdata   = prdata_r;
  assign pready   = pready_r;
  assign pslverr  = pslverr_r;
  assign rx_ready = rx_ready_r;
  assign tx_valid = tx_valid_r;
  assign tx_object = tx_obj_r;
  assign tx_frame = tx_frame_r;
  assign general_irq_pin          = gen_pin_r;
  assign first_object_irq_pin     = first_pin_r;
  assign threshold_object_irq_pin = thr_pin_r;

  // checks
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  AST_GEN_PIN: assert property ( // R3
    ##1 gen_pin_r == ~((|$past(irq_pending_r)) ^ $past(pin_option_config_r[0])))
    else $error("general pin level wrong");
  AST_FIRST_PIN: assert property ( // R4
    rx1_set && pin_option_config_r[1] |=> ##1 first_pin_r)
    else $error("first object pin not raised");
  AST_THR_PIN: assert property ( // R5
    rxx_set && !pin_option_config_r[2] |=> ##1 !thr_pin_r)
    else $error("threshold pin not driven low");
  AST_STD_ID: assert property ( // R8
    store_ev && !cur.extended_format |=>
      mem[$past(scan_idx_r)].object_identifier[28:18] == $past(rx_q_r.id[28:18]))
    else $error("standard id not stored in upper bits");
  AST_FMT: assert property ( // R10
    hit |-> rx_q_r.ide == cur.extended_format)
    else $error("frame format stored in wrong object kind");
  AST_VALID: assert property ( // R13
    hit |-> object_valid_r[scan_idx_r])
    else $error("invalid object matched");
  AST_SCAN_STEP: assert property ( // R14
    state_r == cmof_pkg::CMOF_SCAN && !hit && !last_idx |=>
      scan_idx_r == $past(scan_idx_r) + 5'h01)
    else $error("scan skipped an object");
  AST_REMOTE: assert property ( // R16
    remote_ev && cur.remote_enable |=> transmit_request_r[$past(scan_idx_r)])
    else $error("remote frame did not set transmit request");
  AST_LOST: assert property ( // R19
    store_ev && !cur.object_direction && new_data_flag_r[scan_idx_r] |=>
      mem[$past(scan_idx_r)].message_lost)
    else $error("message lost not flagged");
  AST_TXIE: assert property ( // R20
    tx_ev && txie |=> irq_pending_r[$past(tx_obj_r)])
    else $error("transmit interrupt not pending");
  AST_RXIE: assert property ( // R21
    store_ev && cur.receive_irq_enable |=> irq_pending_r[$past(scan_idx_r)])
    else $error("receive interrupt not pending");
  AST_DLC: assert property ( // R23
    store_ev |=> mem[$past(scan_idx_r)].length_code == $past(rx_q_r.length_code))
    else $error("length code not stored");
  COV_STORE:  cover property (store_ev ##[1:40] store_ev);
  COV_REMOTE: cover property (remote_ev);
  COV_MISS:   cover property (state_r == cmof_pkg::CMOF_SCAN && last_idx && !hit);
  COV_TX:     cover property (tx_valid_r ##[1:20] tx_ev);
endmodule

// file: test/cmof_core_model.sv
// cmof_core_model: protocol core stand-in that offers frames and confirms sends.
// Assumes it shares pclk and presetn with the filter.
`timescale 1ns/1ps
module cmof_core_model (
  // clock and reset
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  // bench side
  input  wire logic                  send,
  input  wire cmof_pkg::cmof_frame_s frame,
  input  wire logic [1:0]            lag,
  // filter side
  output      logic                  rx_valid,
  output      cmof_pkg::cmof_frame_s rx_frame,
  input  wire logic                  rx_ready,
  input  wire logic                  tx_valid,
  output      logic                  tx_done
);
  logic [1:0] wait_r;
  // frame held until taken, then inverted so stale data never looks valid
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_valid <= 1'b0;
      rx_frame <= '0;
    end else if (send) begin
      rx_valid <= 1'b1;
      rx_frame <= frame;
    end else if (rx_valid && rx_ready) begin
      rx_valid <= 1'b0;
      rx_frame <= ~rx_frame;
    end
  end
  // one confirmation per offer, after lag cycles; slow answers are part of the test
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wait_r  <= 2'h0;
      tx_done <= 1'b0;
    end else if (tx_done || !tx_valid) begin
      wait_r  <= 2'h0;
      tx_done <= 1'b0;
    end else if (wait_r == lag) begin
      tx_done <= 1'b1;
    end else begin
      wait_r <= wait_r + 2'h1;
    end
  end
endmodule

// file: test/tb_top.sv
// tb_top: random and corner-case checks of the filter over apb and the core model.
// Assumes a 25 MHz pclk and the register map of the defines header.
`timescale 1ns/1ps
module tb_top;
  logic                  pclk, presetn, psel, penable, pwrite, pready, pslverr, err, send;
  logic                  rx_valid, rx_ready, tx_valid, tx_done;
  logic                  general_irq_pin, first_object_irq_pin, threshold_object_irq_pin;
  logic [11:0]           paddr;
  logic [31:0]           pwdata, prdata, q, rs;
  logic [4:0]            tx_object;
  logic [3:0]            c;
  logic [1:0]            lag;
  logic [28:0]           s, e, f, t;
  logic [63:0]           dat;
  int                    fails, num_checks, n;
  cmof_pkg::cmof_frame_s rx_frame, tx_frame, frame;
  cmof_filter u_cmof_filter (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .rx_valid, .rx_frame, .rx_ready, .tx_valid, .tx_object,
    .tx_frame, .tx_done, .general_irq_pin, .first_object_irq_pin, .threshold_object_irq_pin);
  cmof_core_model u_cmof_core_model (.pclk, .presetn, .send, .frame, .lag, .rx_valid,
    .rx_frame, .rx_ready, .tx_valid, .tx_done);
  // clock
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  function automatic logic [31:0] rnd();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs;
  endfunction
  // arbitration word as the host writes it and reads it back
  function automatic logic [31:0] arb(input logic dir, x, input logic [28:0] id);
    return {1'b0, dir, x, id};
  endfunction
  task automatic chk(input string nm, input logic [63:0] seen, exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // one apb transfer; holds the request until pready is seen high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // no cycle limit here: only the watchdog ends a stalled access
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] x, input string nm);
    apb(1'b0, a, 32'h0);
    chk(nm, q, x);
  endtask
  // mask first, then control, arbitration and data, one register per access
  task automatic obj(input logic [4:0] i, input logic [31:0] m, k, a);
    wr(12'h008, m);
    wr(12'h00C, k);
    wr(12'h010, a);
    wr(12'h014, 32'h0);
    wr(12'h018, 32'h0);
    wr(12'h004, {23'h0, 1'b1, 3'h0, i});
  endtask
  // offer a frame, then wait until the scan is over and the pins have followed
  task automatic rx(input logic [28:0] id, input logic x, r, input logic [3:0] k);
    @(posedge pclk);
    frame <= '{id, x, r, k, dat};
    send  <= 1'b1;
    @(posedge pclk);
    send <= 1'b0;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while ((rx_valid || !rx_ready) && n < 80);
    if (n >= 80) fails++;
    repeat (2) @(posedge pclk);
  endtask
  task automatic txw(input logic [4:0] o, input logic [28:0] id, input logic x, r);
    n = 0;
    while (tx_valid !== 1'b1 && n < 80) begin
      @(posedge pclk);
      n++;
    end
    chk("tx_object", tx_object, o);
    chk("tx_frame", {tx_frame.id, tx_frame.ide, tx_frame.rtr}, {id, x, r});
    while (tx_done !== 1'b1 && n < 80) begin
      @(posedge pclk);
      n++;
    end
    if (n >= 80) fails++;
    repeat (2) @(posedge pclk);
  endtask
  // hang guard, far beyond the few hundred cycles the tests need
  initial begin
    #400000;
    fails++;
    close_out();
  end
  initial begin
    rs = 32'hB283B8EA;
    {fails, num_checks, presetn, psel, penable, pwrite, send} = '0;
    {paddr, pwdata, lag, dat, frame} = '0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    rd(12'h000, 32'h7, "cfg");
    chk("pins", {general_irq_pin, first_object_irq_pin, threshold_object_irq_pin}, 3'h0);
    rd(12'h030, 32'h0, "unmapped");
    chk("slverr", err, 1'b1);
    $display("reset test done");
    q = rnd();
    s = {1'b0, q[9:0], 18'h0};
    e = {1'b1, q[31:4]};
    q = rnd();
    f = {e[28:8], q[7:0]};
    t = {2'h1, q[26:0]};
    obj(5'h0, 32'h0, 32'h0A, arb(1'b0, 1'b0, s));
    obj(5'h2, 32'h9FFFFF00, 32'h08, arb(1'b0, 1'b1, e));
    obj(5'h3, 32'h0, 32'h0A, arb(1'b0, 1'b1, f));
    obj(5'h5, 32'h0, 32'h0D, arb(1'b1, 1'b1, t));
    wr(12'h01C, 32'h2D);
    dat = {rnd(), rnd()};
    rx(s, 1'b1, 1'b0, 4'h8);
    rd(12'h020, 32'h0, "format");
    rx(s, 1'b0, 1'b0, 4'h8);
    rd(12'h020, 32'h1, "newdat");
    rd(12'h024, 32'h1, "irqpnd");
    rd(12'h02C, 32'h3, "pinstat");
    chk("pins", {general_irq_pin, first_object_irq_pin, threshold_object_irq_pin}, 3'h7);
    wr(12'h004, 32'h0);
    rd(12'h010, arb(1'b0, 1'b0, s), "std_id");
    rd(12'h014, dat[31:0], "dlo");
    rd(12'h018, dat[63:32], "dhi");
    rd(12'h00C, 32'h8A, "ctrl");
    $display("store test done");
    q = rnd();
    c = 4'h9 + {1'b0, q[2:0] % 3'h7};
    rx(s, 1'b0, 1'b0, c);
    wr(12'h004, 32'h0);
    rd(12'h00C, {23'h0, 1'b1, c, 4'hA}, "lost_dlc");
    rx(f, 1'b1, 1'b0, 4'h8);
    rd(12'h020, 32'h5, "lowest");
    rd(12'h024, 32'h1, "no_rxie");
    $display("filter test done");
    wr(12'h02C, 32'h3);
    wr(12'h000, 32'h200);
    rx({e[28:8], ~f[7:0]}, 1'b1, 1'b0, 4'h4);
    rd(12'h02C, 32'h2, "thr_flag");
    chk("pins", {general_irq_pin, first_object_irq_pin, threshold_object_irq_pin}, 3'h2);
    $display("polarity test done");
    q = rnd();
    lag = q[1:0];
    rx(t, 1'b1, 1'b1, 4'h0);
    txw(5'h5, t, 1'b1, 1'b0);
    rd(12'h028, 32'h0, "transmit_request");
    rd(12'h024, 32'h21, "txie");
    wr(12'h028, 32'h1);
    txw(5'h0, s, 1'b0, 1'b1);
    rd(12'h024, 32'h21, "no_txie");
    $display("transmit test done");
    wr(12'h024, 32'h21);
    rd(12'h02C, 32'h2, "pinstat");
    chk("pins", {general_irq_pin, first_object_irq_pin, threshold_object_irq_pin}, 3'h6);
    $display("clear test done");
    // two chained receive objects: the second frame must pass the filled first one
    obj(5'h6, 32'h0, 32'h0, arb(1'b0, 1'b1, t));
    obj(5'h7, 32'h0, 32'h08, arb(1'b0, 1'b1, t));
    wr(12'h01C, 32'hED);
    rx(t, 1'b1, 1'b0, 4'h8);
    rx(t, 1'b1, 1'b0, 4'h8);
    rd(12'h020, 32'hC5, "chain");
    $display("chain test done");
    close_out();
  end
endmodule
